// ---- include/guard_timer_params.svh ----
/*
 Constants of the guard timer block: register addresses, field
 positions, reset values and timing counts.
 Assumes inclusion by bare name from the design and the benches.
*/
`ifndef GUARD_TIMER_PARAMS_SVH
`define GUARD_TIMER_PARAMS_SVH

`define WD_ADDR_W            12
`define WD_CTRL_ADDR         12'h060
`define WD_RSRC_ADDR         12'h064
`define WD_CTRL_RESET        8'h00
`define WD_RSRC_RESET        8'h01
`define WD_RSRC_MASK         8'h1f
`define WD_BIT_POWERON       0
`define WD_BIT_PIN           1
`define WD_BIT_BROWNOUT      2
`define WD_BIT_GUARD         3
`define WD_BIT_SCAN          4
`define WD_UNLOCK_CYCLES     3'd4
`define WD_BASE_OSC_CYCLES   2048
`define WD_PS_MAX            4'h9
`define WD_CNT_W             20

`endif

// ---- include/guard_timer_pkg.sv ----
/*
 Types of the guard timer block.
 Assumes the params header sits on the include path.
*/
package guard_timer_pkg;

   // Control register layout, bit 7 first
   typedef struct packed {
      logic       irq_flag;
      logic       irq_en;
      logic       ps3;
      logic       unlock;
      logic       rst_en;
      logic [2:0] ps_lo;
   } wd_ctrl_t;

   // Reset causes coming from the rest of the chip
   typedef struct packed {
      logic scan;
      logic brownout;
      logic pin;
   } rst_cause_t;

   // Timeout action, Gray coded
   typedef enum logic [1:0] {
      MODE_STOP = 2'b00,
      MODE_IRQ  = 2'b01,
      MODE_BOTH = 2'b11,
      MODE_RST  = 2'b10
   } wd_mode_t;

   // Timed change sequence
   typedef enum logic {
      ULK_LOCKED = 1'b0,
      ULK_OPEN   = 1'b1
   } ulk_state_t;

endpackage : guard_timer_pkg

// ---- hdl/guard_timer.sv ----
/*
 Guard timer with control register and reset-source register,
 reached over APB.
 Assumes: pclk 50 MHz; presetn is the power-on reset; the
 oscillator level, restart and reset causes are synchronous.
*/
`timescale 1ns/100ps
`include "guard_timer_params.svh"

module guard_timer #(
   parameter int unsigned BASE_OSC_CYCLES = `WD_BASE_OSC_CYCLES
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [`WD_ADDR_W-1:0]       paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        osc_in,
   input  wire logic                        restart_req,
   input  wire logic                        always_on_fuse,
   input  wire logic                        global_irq_enable,
   input  wire logic                        irq_vector_taken,
   input  wire guard_timer_pkg::rst_cause_t rst_cause,
   output logic                             timeout_irq,
   output logic                             wake_req,
   output logic                             system_reset_req
);
   import guard_timer_pkg::*;

   // ---------------------------------------------------------
   // Functions
   // ---------------------------------------------------------

   // Last count before expiry; reserved codes act as longest
   function automatic logic [`WD_CNT_W-1:0] last_count(
      input logic [3:0] ps
   );
      logic [3:0]  sel;
      logic [31:0] full;
      sel  = (ps > `WD_PS_MAX) ? `WD_PS_MAX : ps;
      full = BASE_OSC_CYCLES << sel;
      last_count = full[`WD_CNT_W-1:0] - 20'h00001;
   endfunction : last_count

   // Address decode shared by read and write paths
   function automatic logic addr_is(
      input logic [`WD_ADDR_W-1:0] a,
      input logic [`WD_ADDR_W-1:0] reg_addr
   );
      addr_is = (a == reg_addr);
   endfunction : addr_is

   // ---------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------

   logic                    irq_flag_ff;
   logic                    irq_en_ff;
   logic                    rst_en_ff;
   logic [3:0]              period_ff;
   logic [7:0]              rsrc_ff;
   logic [`WD_CNT_W-1:0]    cnt_ff;
   logic                    osc_q_ff;
   ulk_state_t              ulk_ff;
   logic [2:0]              ulk_cnt_ff;
   logic                    pready_ff;
   logic                    pslverr_ff;
   logic [31:0]             prdata_ff;
   logic                    irq_ff;
   logic                    wake_ff;
   logic                    sysrst_ff;

   logic                    setup;
   logic                    wr_access;
   logic                    wr_ctrl;
   logic                    wr_rsrc;
   wd_ctrl_t                wd;
   logic                    unlock_req;
   logic                    protected_ok;
   logic                    osc_tick;
   logic                    eff_rst_en;
   logic                    eff_irq_en;
   wd_mode_t                mode;
   logic [3:0]              period;
   logic                    expire;
   logic                    fire_reset;
   logic                    fire_irq;
   logic                    sys_reset_any;
   wd_ctrl_t                ctrl_view;

   // ---------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------

   // Writes land only at the edge that completes the access
   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pwrite & pready_ff;
   assign wr_ctrl   = wr_access & pstrb[0] &
                      addr_is(paddr, `WD_CTRL_ADDR);
   assign wr_rsrc   = wr_access & pstrb[0] &
                      addr_is(paddr, `WD_RSRC_ADDR);
   assign wd        = wd_ctrl_t'(pwdata[7:0]);

   // Unlock needs both bits in one write
   assign unlock_req   = wr_ctrl & wd.unlock & wd.rst_en;
   // Protected fields change only while the window is open
   assign protected_ok = wr_ctrl & ~wd.unlock &
                         (ulk_ff == ULK_OPEN);

   // ---------------------------------------------------------
   // Mode and expiry
   // ---------------------------------------------------------

   // Oscillator edge; the oscillator is far slower than pclk
   assign osc_tick = osc_in & ~osc_q_ff;

   // Fuse and guard flag override the stored enable
   assign eff_rst_en = always_on_fuse |
                       rsrc_ff[`WD_BIT_GUARD] |
                       rst_en_ff;
   assign eff_irq_en = ~always_on_fuse & irq_en_ff;
   assign mode       = wd_mode_t'({eff_rst_en, eff_irq_en});
   assign period     = period_ff;

   // Compare with >= so that a shorter period never wraps past
   // the limit; it expires on the next tick instead
   assign expire = (mode != MODE_STOP) & osc_tick &
                   (cnt_ff >= last_count(period));

   // Combined mode resets when the irq is still unserviced
   assign fire_reset = expire &
                       ((mode == MODE_RST) |
                        ((mode == MODE_BOTH) &
                         irq_flag_ff));
   assign fire_irq   = expire & ~fire_reset &
                       eff_irq_en;

   // Any system reset other than power-on
   assign sys_reset_any = fire_reset | rst_cause.pin |
                          rst_cause.brownout | rst_cause.scan;

   // ---------------------------------------------------------
   // Oscillator edge detect
   // ---------------------------------------------------------

   // Previous oscillator level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_q_ff <= 1'b0;
      end else begin
         osc_q_ff <= osc_in;
      end
   end

   // ---------------------------------------------------------
   // Timeout counter
   // ---------------------------------------------------------

   // Restart instruction and every expiry start a new period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else if ((mode == MODE_STOP) || restart_req ||
                   expire || sys_reset_any) begin
         cnt_ff <= '0;
      end else if (osc_tick) begin
         cnt_ff <= cnt_ff + 20'h00001;
      end
   end

   // ---------------------------------------------------------
   // Timed change window
   // ---------------------------------------------------------

   // Window counts pclk cycles from the unlock write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ulk_ff     <= ULK_LOCKED;
         ulk_cnt_ff <= 3'd0;
      end else begin
         case (ulk_ff)
            ULK_LOCKED: begin
               if (unlock_req) begin
                  ulk_ff     <= ULK_OPEN;
                  ulk_cnt_ff <= `WD_UNLOCK_CYCLES;
               end
            end
            ULK_OPEN: begin
               if (unlock_req) begin
                  ulk_cnt_ff <= `WD_UNLOCK_CYCLES;
               end else if (protected_ok || sys_reset_any) begin
                  ulk_ff     <= ULK_LOCKED;
                  ulk_cnt_ff <= 3'd0;
               end else if (ulk_cnt_ff == 3'd1) begin
                  ulk_ff     <= ULK_LOCKED;
                  ulk_cnt_ff <= 3'd0;
               end else begin
                  ulk_cnt_ff <= ulk_cnt_ff - 3'd1;
               end
            end
            default: begin
               ulk_ff     <= ULK_LOCKED;
               ulk_cnt_ff <= 3'd0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------
   // Control register
   // ---------------------------------------------------------

   // Interrupt flag: a new expiry wins over any clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_ff <= 1'b0;
      end else if (fire_irq) begin
         irq_flag_ff <= 1'b1;
      end else if (sys_reset_any) begin
         irq_flag_ff <= 1'b0;
      end else if (irq_vector_taken ||
                   (wr_ctrl && wd.irq_flag)) begin
         irq_flag_ff <= 1'b0;
      end
   end

   // Interrupt enable; vector in combined mode drops to reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_ff <= 1'b0;
      end else if (sys_reset_any) begin
         irq_en_ff <= 1'b0;
      end else if (irq_vector_taken && (mode == MODE_BOTH)) begin
         irq_en_ff <= 1'b0;
      end else if (wr_ctrl) begin
         irq_en_ff <= wd.irq_en;
      end
   end

   // Reset enable: setting is free, clearing is protected.
   // Own expiry clears it too; the guard flag then holds the effective enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_en_ff <= 1'b0;
      end else if (sys_reset_any) begin
         rst_en_ff <= 1'b0;
      end else if (protected_ok) begin
         rst_en_ff <= wd.rst_en;
      end else if (wr_ctrl && wd.rst_en) begin
         rst_en_ff <= 1'b1;
      end
   end

   // Period select is written only inside the window; any system reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_ff <= 4'h0;
      end else if (sys_reset_any) begin
         period_ff <= 4'h0;
      end else if (protected_ok) begin
         period_ff <= {wd.ps3, wd.ps_lo};
      end
   end

   // Software sees the effective enables, not the stored ones;
   // the unlock bit is shown from the window state, never stored
   always_comb begin
      ctrl_view          = '0;
      ctrl_view.irq_flag = irq_flag_ff;
      ctrl_view.ps3      = period_ff[3];
      ctrl_view.ps_lo    = period_ff[2:0];
      ctrl_view.irq_en   = eff_irq_en;
      ctrl_view.rst_en   = eff_rst_en;
      ctrl_view.unlock   = (ulk_ff == ULK_OPEN);
   end

   // ---------------------------------------------------------
   // Reset-source register
   // ---------------------------------------------------------

   // Writing zero clears a flag, writing one leaves it; a cause
   // present in the same cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsrc_ff <= `WD_RSRC_RESET;
      end else begin
         rsrc_ff[`WD_BIT_POWERON] <=
            (rsrc_ff[`WD_BIT_POWERON] &
             ~(wr_rsrc & ~pwdata[`WD_BIT_POWERON]));
         rsrc_ff[`WD_BIT_PIN] <= rst_cause.pin |
            (rsrc_ff[`WD_BIT_PIN] &
             ~(wr_rsrc & ~pwdata[`WD_BIT_PIN]));
         rsrc_ff[`WD_BIT_BROWNOUT] <=
            rst_cause.brownout |
            (rsrc_ff[`WD_BIT_BROWNOUT] &
             ~(wr_rsrc & ~pwdata[`WD_BIT_BROWNOUT]));
         rsrc_ff[`WD_BIT_GUARD] <= fire_reset |
            (rsrc_ff[`WD_BIT_GUARD] &
             ~(wr_rsrc & ~pwdata[`WD_BIT_GUARD]));
         rsrc_ff[`WD_BIT_SCAN] <= rst_cause.scan |
            (rsrc_ff[`WD_BIT_SCAN] &
             ~(wr_rsrc & ~pwdata[`WD_BIT_SCAN]));
         rsrc_ff[7:5] <= 3'd0;
      end
   end

   // ---------------------------------------------------------
   // Event outputs
   // ---------------------------------------------------------

   // Request to the core needs the global enable too; wake is
   // kept apart since a sleeping core still must see it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff  <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         irq_ff  <= irq_flag_ff & eff_irq_en &
                    global_irq_enable;
         wake_ff <= irq_flag_ff & eff_irq_en;
      end
   end

   // One pclk pulse per watchdog expiry in reset mode, or in combined mode with the irq flag still set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysrst_ff <= 1'b0;
      end else begin
         sysrst_ff <= fire_reset;
      end
   end

   // ---------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------

   // Answer is prepared in the setup cycle so that it comes
   // from flip-flops with no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup &
                       ~addr_is(paddr, `WD_CTRL_ADDR) &
                       ~addr_is(paddr, `WD_RSRC_ADDR);
         if (setup && !pwrite &&
             addr_is(paddr, `WD_CTRL_ADDR)) begin
            prdata_ff <= {24'h000000, ctrl_view};
         end else if (setup && !pwrite &&
                      addr_is(paddr, `WD_RSRC_ADDR)) begin
            prdata_ff <= {24'h000000,
                          rsrc_ff & `WD_RSRC_MASK};
         end else begin
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------

   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign timeout_irq      = irq_ff;
   assign wake_req         = wake_ff;
   assign system_reset_req = sysrst_ff;

endmodule : guard_timer

// ---- tb/guard_timer_asserts.sv ----
/*
 Port-level checker of the guard timer: APB answer timing, read data
 framing, reset pulse shape and interrupt gating.
 Assumes it is bound to guard_timer and sees only its ports.
*/
`timescale 1ns/100ps
`include "guard_timer_params.svh"

module guard_timer_asserts (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic [`WD_ADDR_W-1:0]       paddr,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        always_on_fuse,
   input wire logic                        global_irq_enable,
   input wire logic                        timeout_irq,
   input wire logic                        wake_req,
   input wire logic                        system_reset_req
);
   import guard_timer_pkg::*;

   // -----------------------------------------------------------
   // Properties
   // -----------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic mapped;
   // Only the two register words answer without error
   assign mapped = (paddr == `WD_CTRL_ADDR) || (paddr == `WD_RSRC_ADDR);

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing in access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("error on mapped address");
   a_rdata_idle: assert property (!pready || pslverr |-> prdata == 32'h0)
      else $error("read data outside a good answer");
   a_rdata_upper: assert property (prdata[31:8] == 24'h0)
      else $error("upper read data bits set");
   a_reset_single_pulse: assert property (
      system_reset_req |=> !system_reset_req)
      else $error("system reset request longer than one cycle");
   a_irq_needs_gie: assert property (
      timeout_irq |-> $past(global_irq_enable) && wake_req)
      else $error("interrupt without both enables");
   a_fuse_blocks_irq: assert property (
      $past(always_on_fuse) |-> !wake_req)
      else $error("interrupt path open with fuse set");
endmodule : guard_timer_asserts

bind guard_timer guard_timer_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
   .timeout_irq(timeout_irq), .wake_req(wake_req),
   .system_reset_req(system_reset_req)
);

// ---- tb/tb.sv ----
/*
 Self-checking bench of the guard timer: registers over APB, the
 timed change sequence, the irq, combined and reset timeout modes and reset-cause flags.
 Assumes the base count is shortened to 4 oscillator cycles.
*/
`timescale 1ns/100ps
`include "guard_timer_params.svh"

module tb;
   import guard_timer_pkg::*;

   // -----------------------------------------------------------
   // Signals and design
   // -----------------------------------------------------------
   localparam logic [11:0] CTRL = `WD_CTRL_ADDR;
   localparam logic [11:0] RSRC = `WD_RSRC_ADDR;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [3:0]  pstrb = 0;
   logic [3:0]  strb = 4'hf;
   logic pready, pslverr, timeout_irq, wake_req, system_reset_req;
   logic osc_in = 0, restart_req = 0, always_on_fuse = 0;
   logic global_irq_enable = 1, irq_vector_taken = 0;
   rst_cause_t rst_cause = '0;
   int failures = 0, comparisons = 0, cycles = 0, n_rst = 0, n_irq = 0;
   int r0, i0;
   logic [31:0] rd;
   logic err;

   guard_timer #(.BASE_OSC_CYCLES(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_in(osc_in), .restart_req(restart_req),
      .always_on_fuse(always_on_fuse),
      .global_irq_enable(global_irq_enable),
      .irq_vector_taken(irq_vector_taken), .rst_cause(rst_cause),
      .timeout_irq(timeout_irq), .wake_req(wake_req),
      .system_reset_req(system_reset_req));

   // Clock, event counters and the hang limit
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (system_reset_req === 1'b1) n_rst++;
      if (timeout_irq === 1'b1) n_irq++;
      if (cycles == 60000) begin
         failures++;
         close_out();
      end
   end

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic close_out();
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
      pwdata <= {24'h0, d}; pstrb <= strb;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1, a, d);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      apb(0, a, 8'h0);
      check(rd, {24'h0, e});
   endtask : rdchk

   // Fresh power-on reset, held for 10 cycles
   task automatic por();
      presetn <= 0;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
   endtask : por

   // Oscillator runs only here, at 400 pclk cycles a period
   task automatic ticks(input int n);
      repeat (n) begin
         repeat (200) @(posedge pclk);
         osc_in <= 1;
         repeat (200) @(posedge pclk);
         osc_in <= 0;
      end
      repeat (4) @(posedge pclk);
   endtask : ticks

   task automatic restart();
      @(posedge pclk) restart_req <= 1;
      @(posedge pclk) restart_req <= 0;
   endtask : restart

   task automatic vector();
      @(posedge pclk) irq_vector_taken <= 1;
      @(posedge pclk) irq_vector_taken <= 0;
   endtask : vector

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_regs();
      por();
      rdchk(CTRL, 8'h00);
      rdchk(RSRC, 8'h01);
      wr(RSRC, 8'hff);
      rdchk(RSRC, 8'h01);
      wr(RSRC, 8'hfe);
      rdchk(RSRC, 8'h00);
      apb(0, 12'h068, 8'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      // A write with the low strobe off must not land
      strb = 4'h0;
      wr(CTRL, 8'h08);
      strb = 4'hf;
      rdchk(CTRL, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(RSRC, 8'h00);
         @(posedge pclk) rst_cause <= rst_cause_t'(3'b001 << i);
         @(posedge pclk) rst_cause <= '0;
         rdchk(RSRC, (i == 0) ? 8'h02 : (i == 1) ? 8'h04 : 8'h10);
      end
   endtask : t_regs

   task automatic t_irq();
      por();
      wr(CTRL, 8'h40);
      restart();
      ticks(3);
      restart(); // Restart just before expiry holds it off
      ticks(3);
      rdchk(CTRL, 8'h40);
      i0 = n_irq;
      ticks(1);
      rdchk(CTRL, 8'hc0);
      check(n_irq > i0, 1);
      wr(CTRL, 8'hc0);
      rdchk(CTRL, 8'h40);
      global_irq_enable <= 0;
      i0 = n_irq;
      ticks(4);
      check(n_irq, i0);
      check(wake_req, 1);
      vector();
      rdchk(CTRL, 8'h40);
      global_irq_enable <= 1;
   endtask : t_irq

   task automatic t_window();
      por();
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h41);
      rdchk(CTRL, 8'h41);
      restart();
      ticks(7);
      rdchk(CTRL, 8'h41);
      ticks(1);
      rdchk(CTRL, 8'hc1);
      wr(CTRL, 8'hc1);
      wr(CTRL, 8'h58);
      repeat (6) @(posedge pclk);
      rdchk(CTRL, 8'h49);
      wr(CTRL, 8'h40);
      rdchk(CTRL, 8'h49);
      r0 = n_rst;
      restart();
      ticks(8);
      rdchk(CTRL, 8'hc9);
      check(n_rst, r0);
      ticks(8);
      check(n_rst, r0 + 1);
      rdchk(RSRC, 8'h09);
      rdchk(CTRL, 8'h08);
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h08);
      wr(RSRC, 8'h01);
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h00);
      rdchk(CTRL, 8'h00);
   endtask : t_window

   task automatic t_vector_fuse();
      por();
      wr(CTRL, 8'h48);
      restart();
      ticks(4);
      rdchk(CTRL, 8'hc8);
      vector();
      rdchk(CTRL, 8'h08);
      por();
      always_on_fuse <= 1;
      wr(CTRL, 8'h40);
      rdchk(CTRL, 8'h08);
      r0 = n_rst;
      restart();
      ticks(4);
      check(n_rst, r0 + 1);
      always_on_fuse <= 0;
   endtask : t_vector_fuse

   // Main sequence
   initial begin
      por();
      t_regs();
      t_irq();
      t_window();
      t_vector_fuse();
      close_out();
   end
endmodule : tb
